//--- hw/ssq_params.svh
// Purpose: constants of the stepped sweep sequencer
// Assumes: 10 MHz clock, APB byte addresses
// Notes: definitions only
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH
// ****************************************
// register map
// ****************************************
`define SSQ_BANK_FREQ 8'h00
`define SSQ_BANK_POWER 8'h20
`define SSQ_BANK_COMMON 8'h40
`define SSQ_O_STEP 5'h00
`define SSQ_O_DWELL 5'h04
`define SSQ_O_CFG 5'h08
`define SSQ_O_COUNT 5'h0C
`define SSQ_O_START 5'h10
`define SSQ_O_STOP 5'h14
`define SSQ_O_STATUS 5'h00
`define SSQ_O_MASK 5'h04
`define SSQ_O_STATE 5'h08
// ****************************************
// fields, codes and reset values
// ****************************************
`define SSQ_LINK_DWELL 3'h0
`define SSQ_LINK_TRIG_MAX 3'h4
`define SSQ_LINK_TRIG_NOIDX 3'h7
`define SSQ_LINK_TRIG_ONE 3'h1
`define SSQ_CFG_GEN 12
`define SSQ_CFG_SPACE 13
`define SSQ_CFG_DIR 8
`define SSQ_FSTEP_RST 32'h3B9ACA00
`define SSQ_PSTEP_RST 32'h0000000A
`define SSQ_DWELL_RST 32'h000009C4
`define SSQ_FDWELL_MIN 32'h000003E8
`define SSQ_PDWELL_MIN 32'h000001F4
`define SSQ_DWELL_MAX 32'h1312D000
`define SSQ_COUNT_MAX 32'h00007D00
// ****************************************
// timing
// ****************************************
`define SSQ_CLK_NS 100
`define SSQ_TICK_NS 100000
`define SSQ_TICK_CYC (`SSQ_TICK_NS / `SSQ_CLK_NS)
`endif

//--- hw/ssq_pkg.sv
// Purpose: types of the stepped sweep sequencer
// Assumes: nothing
// Notes: constants live in ssq_params.svh
package ssq_pkg;
  typedef enum logic [1:0] {SSQ_IDLE, SSQ_SETTLE, SSQ_DWELL} ssq_state_e;
endpackage

//--- hw/ssq_sweep_top.sv
// Purpose: stepped frequency and power sweep control, APB registers
// Assumes: 10 MHz clock, sync reset, async trigger and settle pins
// Notes: sweep 0 is frequency (Hz), sweep 1 is power (0.1 dB units)
// Contract
// - sweep value moves only in whole discrete steps
// - step advance from dwell timer or one of four triggers
// - after reset advance source is the dwell timer
// - trigger choice without index equals trigger one
// - frequency sweep start trigger selectable, resets to one
// - power sweep start trigger independent, resets to one
// - frequency step 1 Hz units, 1 Hz to range, reset 1 GHz
// - power step 0.1 dB units, 0.1 dB to range, reset 1 dB
// - out of range settings rejected and flag an error
// - generation reads stepped for both sweeps
// - spacing reads linear for both sweeps
// - index one addresses frequency, index two power settings
// - dwell 0.1 ms units, reset 0.25 s, per sweep minimum
// - dwell begins only after hardware has settled
// - one start trigger repeats sweep count times, 1..32000
// - per sweep direction, reset upward
//
// The implementer's own choices: the placing of the registers and register access over APB.
`include "ssq_params.svh"
`timescale 1ns/10ps
module ssq_sweep_top import ssq_pkg::*; #(
  parameter logic [31:0] F_RANGE = 32'h7FFFFFFF,
  parameter logic [31:0] P_RANGE = 32'h00000258
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // trigger sequences and settle pins
  input wire logic [3:0] TRIG_I,
  input wire logic [1:0] SETTLED_I,
  // swept values to the source hardware
  output logic [31:0] FREQ_O,
  output logic [31:0] POWER_O,
  output logic [1:0] LOAD_O,
  // interrupt
  output logic IRQ_O
);
  // ****************************************
  // state
  // ****************************************
  logic [31:0] step [2];
  logic [31:0] dwell [2];
  logic [31:0] lo [2];
  logic [31:0] hi [2];
  logic [14:0] count [2];
  logic [2:0] dwell_timer_link [2];
  logic [1:0] start_seq [2];
  logic [1:0] dir_dn;
  ssq_state_e st [2];
  logic [31:0] val [2];
  logic [14:0] pass [2];
  logic [31:0] dcnt [2];
  logic [1:0] ld;
  logic [1:0] done;
  logic [2:0] status;
  logic [2:0] mask;
  logic [9:0] tdiv;
  logic tick;
  logic [3:0] t1, t2, t3;
  logic [1:0] z1, z2, z3;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic irq;

  function automatic logic in_rng(input logic [31:0] v, input logic [31:0] a,
                                  input logic [31:0] b);
    return (v >= a) && (v <= b);
  endfunction

  // ****************************************
  // apb decode
  // ****************************************
  wire acc = PSEL_I & PENABLE_I;
  wire fin = acc & pready;
  wire wr = fin & PWRITE_I;
  wire [4:0] o = PADDR_I[4:0];
  wire s = PADDR_I[5];
  wire in_bank = (PADDR_I[7:6] == 2'h0);
  wire in_com = (PADDR_I[7:5] == 3'h2);
  wire [31:0] rng = s ? P_RANGE : F_RANGE;
  wire [31:0] dmin = s ? `SSQ_PDWELL_MIN : `SSQ_FDWELL_MIN;
  wire [2:0] wlink = PWDATA_I[2:0];
  wire link_ok = (wlink <= `SSQ_LINK_TRIG_MAX) | (wlink == `SSQ_LINK_TRIG_NOIDX);
  // bare trigger code folds to one
  wire [2:0] link_w = (wlink == `SSQ_LINK_TRIG_NOIDX) ? `SSQ_LINK_TRIG_ONE : wlink;
  wire w_step = in_bank & (o == `SSQ_O_STEP);
  wire w_dwell = in_bank & (o == `SSQ_O_DWELL);
  wire w_cfg = in_bank & (o == `SSQ_O_CFG);
  wire w_count = in_bank & (o == `SSQ_O_COUNT);
  wire w_start = in_bank & (o == `SSQ_O_START);
  wire w_stop = in_bank & (o == `SSQ_O_STOP);
  wire w_stat = in_com & (o == `SSQ_O_STATUS);
  wire w_mask = in_com & (o == `SSQ_O_MASK);
  wire w_state = in_com & (o == `SSQ_O_STATE);
  wire mapped = w_step | w_dwell | w_cfg | w_count | w_start | w_stop |
                w_stat | w_mask | w_state;
  wire val_ok = w_step ? in_rng(PWDATA_I, 32'h1, rng) :
                w_dwell ? in_rng(PWDATA_I, dmin, `SSQ_DWELL_MAX) :
                w_cfg ? link_ok :
                w_count ? in_rng(PWDATA_I, 32'h1, `SSQ_COUNT_MAX) :
                (w_start | w_stop) ? (PWDATA_I <= rng) : 1'b1;
  wire wbad = wr & mapped & ~val_ok;
  wire wgood = wr & mapped & val_ok;
  // config reads fixed step and linear
  wire [31:0] cfg_rd = {18'h0, 1'b0, 1'b1, 3'h0, dir_dn[s], 2'h0,
                        start_seq[s], 1'b0, dwell_timer_link[s]};
  wire [31:0] state_rd = {28'h0, st[1] != SSQ_IDLE, 1'b0, st[0] != SSQ_IDLE, 1'b0};
  wire [31:0] rd_mux = w_step ? step[s] : w_dwell ? dwell[s] : w_cfg ? cfg_rd :
                       w_count ? {17'h0, count[s]} : w_start ? lo[s] :
                       w_stop ? hi[s] : w_stat ? {29'h0, status} :
                       w_mask ? {29'h0, mask} : w_state ? state_rd : 32'h0;

  // apb answer: one wait cycle, then pready
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      rdata <= 32'h0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~(mapped & (~PWRITE_I | val_ok));
      rdata <= (acc & ~pready & ~PWRITE_I) ? rd_mux : 32'h0;
    end
  end

  // ****************************************
  // settings registers
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      step[0] <= `SSQ_FSTEP_RST;
      step[1] <= `SSQ_PSTEP_RST;
      for (int i = 0; i < 2; i++) begin
        dwell[i] <= `SSQ_DWELL_RST;
        lo[i] <= 32'h0;
        hi[i] <= (i == 0) ? F_RANGE : P_RANGE;
        count[i] <= 15'h1;
        dwell_timer_link[i] <= `SSQ_LINK_DWELL;
        start_seq[i] <= 2'h0;
      end
      dir_dn <= 2'h0;
      mask <= 3'h0;
    end else if (wgood) begin
      if (w_step) step[s] <= PWDATA_I;
      if (w_dwell) dwell[s] <= PWDATA_I;
      if (w_count) count[s] <= PWDATA_I[14:0];
      if (w_start) lo[s] <= PWDATA_I;
      if (w_stop) hi[s] <= PWDATA_I;
      if (w_mask) mask <= PWDATA_I[2:0];
      if (w_cfg) begin
        dwell_timer_link[s] <= link_w;
        start_seq[s] <= PWDATA_I[5:4];
        dir_dn[s] <= PWDATA_I[`SSQ_CFG_DIR];
      end
    end
  end

  // ****************************************
  // pin synchronisers and tick
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      t1 <= 4'h0;
      t2 <= 4'h0;
      t3 <= 4'h0;
      z1 <= 2'h0;
      z2 <= 2'h0;
      z3 <= 2'h0;
    end else begin
      t1 <= TRIG_I;
      t2 <= t1;
      t3 <= t2;
      z1 <= SETTLED_I;
      z2 <= z1;
      z3 <= z2;
    end
  end

  wire [3:0] tedge = t2 & ~t3;
  wire [1:0] sedge = z2 & ~z3;

  // 0.1 ms dwell tick
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      tdiv <= 10'h0;
      tick <= 1'b0;
    end else begin
      tick <= (tdiv == 10'(`SSQ_TICK_CYC - 1));
      tdiv <= (tdiv == 10'(`SSQ_TICK_CYC - 1)) ? 10'h0 : tdiv + 10'h1;
    end
  end

  // ****************************************
  // sweep engines
  // ****************************************
  logic [1:0] go, adv, at_end;
  logic [31:0] org [2];
  logic [31:0] nxt [2];
  for (genvar g = 0; g < 2; g++) begin : g_sw
    assign go[g] = tedge[start_seq[g]];
    assign adv[g] = (dwell_timer_link[g] == `SSQ_LINK_DWELL) ? (dcnt[g] >= dwell[g]) :
                    tedge[2'(dwell_timer_link[g] - 3'h1)];
    assign org[g] = dir_dn[g] ? hi[g] : lo[g];
    assign nxt[g] = dir_dn[g] ? val[g] - step[g] : val[g] + step[g];
    // no room for a further step
    assign at_end[g] = dir_dn[g] ? ((val[g] < lo[g]) | (val[g] - lo[g] < step[g])) :
                       ((hi[g] < val[g]) | (hi[g] - val[g] < step[g]));
  end

  // sequence per sweep
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < 2; i++) begin
        st[i] <= SSQ_IDLE;
        val[i] <= 32'h0;
        pass[i] <= 15'h0;
        dcnt[i] <= 32'h0;
      end
      ld <= 2'h0;
      done <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        ld[i] <= 1'b0;
        done[i] <= 1'b0;
        unique case (st[i])
          SSQ_IDLE: begin
            if (go[i]) begin
              val[i] <= org[i];
              pass[i] <= count[i];
              ld[i] <= 1'b1;
              st[i] <= SSQ_SETTLE;
            end
          end
          SSQ_SETTLE: begin
            if (sedge[i]) begin
              dcnt[i] <= 32'h0;
              st[i] <= SSQ_DWELL;
            end
          end
          SSQ_DWELL: begin
            if (tick) dcnt[i] <= dcnt[i] + 32'h1;
            if (adv[i]) begin
              ld[i] <= 1'b1;
              st[i] <= SSQ_SETTLE;
              if (!at_end[i]) begin
                val[i] <= nxt[i];
              end else if (pass[i] <= 15'h1) begin
                ld[i] <= 1'b0;
                done[i] <= 1'b1;
                st[i] <= SSQ_IDLE;
              end else begin
                pass[i] <= pass[i] - 15'h1;
                val[i] <= org[i];
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // status, mask and interrupt
  // ****************************************
  wire [2:0] w1c = (wr & w_stat) ? PWDATA_I[2:0] : 3'h0;
  wire [2:0] ev = {done, wbad};

  // set wins over write one to clear
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      status <= 3'h0;
      irq <= 1'b0;
    end else begin
      status <= (status & ~w1c) | ev;
      irq <= |(status & mask);
    end
  end

  // outputs straight from flops
  assign PRDATA_O = rdata;
  assign PREADY_O = pready;
  assign PSLVERR_O = pslverr;
  assign FREQ_O = val[0];
  assign POWER_O = val[1];
  assign LOAD_O = ld;
  assign IRQ_O = irq;

  // ****************************************
  // assertions
  // ****************************************
  a_ready_wait: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    pready |-> $past(acc) && !$past(pready))
    else $error("pready without wait cycle");
  a_link_reset: assert property (@(posedge CLOCK_I)
    $fell(SRST_I) |-> dwell_timer_link[0] == 3'h0 && dwell_timer_link[1] == 3'h0)
    else $error("advance source not dwell after reset");
  a_noidx_alias: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (wr && w_cfg && !s && wlink == 3'h7) |=> dwell_timer_link[0] == 3'h1)
    else $error("bare trigger code not trigger one");
  a_step_reject: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (wr && w_step && PWDATA_I == 32'h0) |=> status[0] && $stable(step[0]) && $stable(step[1]))
    else $error("bad step not rejected");
  a_gen_step: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (acc && !pready && !PWRITE_I && w_cfg) |=> rdata[12])
    else $error("generation not stepped");
  a_space_lin: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (acc && !pready && !PWRITE_I && w_cfg) |=> !rdata[13])
    else $error("spacing not linear");
  a_one_step: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (st[0] == SSQ_DWELL && adv[0] && !at_end[0] && !dir_dn[0])
    |=> ld[0] && val[0] == $past(val[0]) + $past(step[0]))
    else $error("frequency not one step up");
  a_settle_hold: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (st[1] == SSQ_SETTLE && !sedge[1]) |=> st[1] == SSQ_SETTLE)
    else $error("dwell before settle");
  a_dwell_time: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (st[0] == SSQ_DWELL && dwell_timer_link[0] == 3'h0 && dcnt[0] < dwell[0])
    |=> st[0] == SSQ_DWELL && !ld[0])
    else $error("dwell cut short");
  a_last_pass: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    done[1] |-> $past(pass[1]) <= 15'h1 && st[1] == SSQ_IDLE)
    else $error("sweep ended early");
  a_irq_mask: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    IRQ_O |-> $past(|(status & mask)))
    else $error("irq without masked status");
endmodule

//--- dv/ssq_hw_model.sv
// Purpose: source hardware model, reports settling after each load
// Assumes: one load pulse per new swept value
// Notes: frequency side settles fast, power side slowly
`timescale 1ns/10ps
module ssq_hw_model #(
  parameter int FAST_CYC = 6,
  parameter int SLOW_CYC = 60
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // load pulses in, settle levels out
  input wire logic [1:0] load_i,
  output logic [1:0] settled_o
);
  int cnt [2];
  // ****************************************
  // settle timers
  // ****************************************
  // settle must fall on every load so the next rising edge is seen
  always @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (srst_i) begin
        settled_o[k] <= 1'h0;
        cnt[k] <= 0;
      end else if (load_i[k]) begin
        settled_o[k] <= 1'h0;
        cnt[k] <= (k == 0) ? FAST_CYC : SLOW_CYC;
      end else if (cnt[k] > 0) begin
        cnt[k] <= cnt[k] - 1;
        settled_o[k] <= (cnt[k] == 1);
      end
    end
  end
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench of the stepped sweep sequencer
// Assumes: 10 MHz clock, one wait state on every register access
// Notes: stepping runs on trigger links, timer dwell is far too long
`timescale 1ns/10ps
module tb;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, freq, power;
  logic pready, pslverr, irq;
  logic [3:0] trig = 4'h0;
  logic [1:0] settled, load;
  int num_errors = 0;
  int comparisons = 0;
  // ****************************************
  // clock, design and hardware model
  // ****************************************
  always #50 clk = ~clk;
  ssq_sweep_top i_dut (.CLOCK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TRIG_I(trig), .SETTLED_I(settled),
    .FREQ_O(freq), .POWER_O(power), .LOAD_O(load), .IRQ_O(irq));
  ssq_hw_model i_hw (.clk_i(clk), .srst_i(srst), .load_i(load), .settled_o(settled));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h00000000, r, e);
    chk("read data", exp, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
    chk("pslverr", {31'h0, err}, {31'h0, e});
  endtask
  // raise a trigger pin, look for a load, release the pin
  task automatic step(input int k, input int t, input logic [31:0] exp, input logic ld);
    int n;
    n = 0;
    trig[t] <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (load[k] !== 1'h1 && n < 40);
    trig[t] <= 1'h0;
    chk("load", {31'h0, ld}, {31'h0, load[k]});
    if (ld) chk("swept value", exp, k == 0 ? freq : power);
    repeat (4) @(posedge clk);
  endtask
  task automatic settle(input int k);
    int n;
    n = 0;
    @(posedge clk);
    while (settled[k] !== 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(8'h00, 32'h3B9ACA00);
    rd(8'h20, 32'h0000000A);
    rd(8'h04, 32'h000009C4);
    rd(8'h24, 32'h000009C4);
    rd(8'h08, 32'h00001000);
    rd(8'h28, 32'h00001000);
    rd(8'h0C, 32'h00000001);
    rd(8'h2C, 32'h00000001);
    rd(8'h48, 32'h00000000);
    $display("test reset defaults done");
  endtask
  task automatic t_limits();
    wr(8'h08, 32'h00003007, 1'h0);
    rd(8'h08, 32'h00001001);
    wr(8'h08, 32'h00000005, 1'h1);
    wr(8'h28, 32'h00000006, 1'h1);
    wr(8'h00, 32'h00000000, 1'h1);
    wr(8'h00, 32'h80000000, 1'h1);
    wr(8'h00, 32'h7FFFFFFF, 1'h0);
    wr(8'h20, 32'h00000259, 1'h1);
    wr(8'h20, 32'h00000000, 1'h1);
    wr(8'h20, 32'h00000258, 1'h0);
    wr(8'h04, 32'h000003E7, 1'h1);
    wr(8'h24, 32'h000001F4, 1'h0);
    wr(8'h0C, 32'h00007D01, 1'h1);
    wr(8'h0C, 32'h00000000, 1'h1);
    wr(8'h0C, 32'h00007D00, 1'h0);
    rd(8'h00, 32'h7FFFFFFF);
    rd(8'h20, 32'h00000258);
    rd(8'h24, 32'h000001F4);
    wr(8'h60, 32'h00000005, 1'h1);
    rd(8'h60, 32'h00000000);
    $display("test limits done");
  endtask
  task automatic t_irq();
    rd(8'h40, 32'h00000001);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h44, 32'h00000001, 1'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h40, 32'h00000001, 1'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h40, 32'h00000000);
    wr(8'h44, 32'h00000006, 1'h0);
    $display("test interrupt done");
  endtask
  // power sweep moved off trigger one first, else both sweeps start together
  task automatic t_freq();
    wr(8'h28, 32'h00000124, 1'h0);
    wr(8'h10, 32'h00000064, 1'h0);
    wr(8'h14, 32'h00000082, 1'h0);
    wr(8'h00, 32'h0000000A, 1'h0);
    wr(8'h0C, 32'h00000002, 1'h0);
    wr(8'h08, 32'h00000002, 1'h0);
    step(0, 0, 32'h00000064, 1'h1);
    rd(8'h48, 32'h00000002);
    for (int j = 1; j < 8; j++) begin
      settle(0);
      step(0, 1, 32'h00000064 + 32'h0000000A * (j % 4), 1'h1);
    end
    settle(0);
    step(0, 1, 32'h00000000, 1'h0);
    rd(8'h40, 32'h00000002);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h40, 32'h00000002, 1'h0);
    $display("test frequency sweep done");
  endtask
  task automatic t_power();
    wr(8'h30, 32'h00000005, 1'h0);
    wr(8'h34, 32'h00000023, 1'h0);
    wr(8'h20, 32'h0000000A, 1'h0);
    wr(8'h28, 32'h00000124, 1'h0);
    step(1, 2, 32'h00000023, 1'h1);
    step(1, 3, 32'h00000000, 1'h0);
    for (int j = 1; j < 4; j++) begin
      settle(1);
      step(1, 3, 32'h00000023 - 32'h0000000A * j, 1'h1);
    end
    settle(1);
    step(1, 3, 32'h00000000, 1'h0);
    rd(8'h40, 32'h00000004);
    chk("frequency held", 32'h00000082, freq);
    wr(8'h40, 32'h00000004, 1'h0);
    $display("test power sweep done");
  endtask
  // timer link ignores triggers, then a reset in mid sweep
  task automatic t_dwell();
    wr(8'h08, 32'h00000000, 1'h0);
    step(0, 0, 32'h00000064, 1'h1);
    settle(0);
    step(0, 1, 32'h00000000, 1'h0);
    rd(8'h48, 32'h00000002);
    srst <= 1'h1;
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    chk("frequency", 32'h00000000, freq);
    t_reset();
    $display("test dwell link and reset done");
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    t_reset();
    t_limits();
    t_irq();
    t_freq();
    t_power();
    t_dwell();
    conclude();
  end
  // watchdog at 40000 cycles, far beyond the expected run of about a thousand cycles
  initial begin
    #4000000;
    num_errors++;
    conclude();
  end
endmodule
